// File: common/ire_pkg.sv
// Constants, field layouts and carrier types for the infrared pulse encoder control
`default_nettype none

package ire_pkg;

  // Register word offsets (byte addresses)
  localparam logic [3:0] IRE_OFS_CTRL     = 4'h0;
  localparam logic [3:0] IRE_OFS_RATE     = 4'h4;
  localparam logic [3:0] IRE_OFS_STATUS   = 4'h8;

  // Control field positions
  localparam int IRE_CTRL_EN_BIT       = 7;
  localparam int IRE_CTRL_WIDTH_LSB    = 4;
  localparam int IRE_CTRL_TXINV_BIT    = 3;
  localparam int IRE_CTRL_RXINV_BIT    = 2;
  localparam logic [7:0] IRE_CTRL_WMASK = 8'hFC;
  localparam logic [7:0] IRE_CTRL_RESET = 8'h00;

  // Bit rate register fields
  localparam int IRE_RATE_DIV_LSB      = 0;
  localparam int IRE_RATE_PRE_LSB      = 8;
  localparam int IRE_RATE_SMART_BIT    = 16;
  localparam logic [10:0] IRE_RATE_RESET = 11'h000;

  // Clocks per bit at prescaler 0 and divisor 0
  localparam int IRE_ASYNC_BASE        = 32;
  localparam int IRE_SMART_FACTOR      = 372;
  localparam int IRE_SMART_BASE        = 2 * IRE_SMART_FACTOR;

  // Short-pulse fraction of a bit period: 3/16
  localparam int IRE_FRAC_NUM          = 3;
  localparam int IRE_FRAC_SHIFT        = 4;

  localparam int IRE_CNT_W             = 24;

  typedef struct packed {
    logic       enable;
    logic [2:0] width_sel;
    logic       tx_inv;
    logic       rx_inv;
    logic [1:0] rsvd;
  } ire_ctrl_s;

  typedef struct packed {
    logic       smart;
    logic [1:0] prescale;
    logic [7:0] divisor;
  } ire_rate_s;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } ire_av_req_s;

  typedef enum logic [1:0] {
    IRE_IDLE  = 2'b00,
    IRE_PULSE = 2'b01,
    IRE_GAP   = 2'b10
  } ire_state_e;

endpackage : ire_pkg

`default_nettype wire

// File: core/ire_top.sv
// Infrared pulse encoder control for serial channel 0 with register slave
//
// The address map and the Avalon-MM slave port were left to the implementer.
`default_nettype none

module ire_top #(
  parameter int N_OTHER = 1
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  // Avalon-MM slave
  input  wire ire_pkg::ire_av_req_s  i_av,
  output logic [31:0]                o_av_readdata,
  output logic                       o_av_waitrequest,
  // Serial core channel 0
  input  wire logic                  i_core_txd,
  input  wire logic                  i_core_bit_stb,
  output logic                       o_core_rxd,
  // Channel 0 pins
  output logic                       o_serial_tx_pin_ch0,
  input  wire logic                  i_serial_rx_pin_ch0,
  // Other channels
  input  wire logic [N_OTHER-1:0]    i_other_txd,
  output logic [N_OTHER-1:0]         o_other_tx_pin,
  input  wire logic [N_OTHER-1:0]    i_other_rx_pin,
  output logic [N_OTHER-1:0]         o_other_rxd
);
  import ire_pkg::*;

  if (N_OTHER < 1 || N_OTHER > 8) begin : g_chk
    $error("N_OTHER must be 1 to 8");
  end

  // Clocks in one bit period; also used by status readback
  function automatic logic [IRE_CNT_W-1:0] bit_period(input ire_rate_s r);
    logic [IRE_CNT_W-1:0] base;
    logic [IRE_CNT_W-1:0] scaled;
    base   = r.smart ? IRE_CNT_W'(IRE_SMART_BASE) : IRE_CNT_W'(IRE_ASYNC_BASE);
    scaled = base << (2 * r.prescale);
    return IRE_CNT_W'(scaled * ({16'h0000, r.divisor} + 24'h000001));
  endfunction : bit_period

  // Pulse width in clocks for a width code
  function automatic logic [IRE_CNT_W-1:0] pulse_width(input logic [2:0] sel,
                                                        input logic [IRE_CNT_W-1:0] per);
    logic [IRE_CNT_W+1:0] frac;
    frac = (IRE_CNT_W+2)'(per) * (IRE_CNT_W+2)'(IRE_FRAC_NUM);
    if (sel == 3'h0) begin
      return IRE_CNT_W'(frac >> IRE_FRAC_SHIFT);
    end
    return IRE_CNT_W'(24'h000001 << sel);
  endfunction : pulse_width

  ire_ctrl_s             ctrl_q;
  ire_rate_s             rate_q;
  logic                  ack_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rx0_sync_q;
  logic [N_OTHER-1:0]    rxo_meta_q;
  logic [N_OTHER-1:0]    rxo_sync_q;
  ire_state_e            state_q;
  ire_state_e            state_d;
  logic [IRE_CNT_W-1:0]  cnt_q;
  logic [IRE_CNT_W-1:0]  cnt_d;
  logic                  tx_pin_q;
  logic                  rxd_q;
  logic [N_OTHER-1:0]    other_tx_q;

  // Bus decode
  wire        req        = i_av.read | i_av.write;
  wire        take       = req & ~ack_q;
  wire        hit_ctrl   = (i_av.address == IRE_OFS_CTRL);
  wire        hit_rate   = (i_av.address == IRE_OFS_RATE);
  wire        hit_stat   = (i_av.address == IRE_OFS_STATUS);
  wire        wr_ctrl    = take & i_av.write & hit_ctrl & i_av.byteenable[0];
  wire        wr_rate_b0 = take & i_av.write & hit_rate & i_av.byteenable[0];
  wire        wr_rate_b1 = take & i_av.write & hit_rate & i_av.byteenable[1];
  wire        wr_rate_b2 = take & i_av.write & hit_rate & i_av.byteenable[2];

  wire [IRE_CNT_W-1:0] period = bit_period(rate_q);
  wire [IRE_CNT_W-1:0] width  = pulse_width(ctrl_q.width_sel, period);
  wire                 pulsing = (state_q == IRE_PULSE);

  wire [31:0] rd_ctrl = {24'h000000, ctrl_q};
  wire [31:0] rd_rate = {15'h0000, rate_q.smart, 6'h00, rate_q.prescale, rate_q.divisor};
  wire [31:0] rd_stat = {period, 4'h0, pulsing, tx_pin_q, rxd_q, rx0_sync_q[1]};
  wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl :
                        hit_rate ? rd_rate :
                        hit_stat ? rd_stat : 32'h00000000;

  // One wait cycle, then the answer
  assign o_av_waitrequest = req & ~ack_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q   <= take;
      rdata_q <= take ? rd_mux : rdata_q;
    end
  end
  assign o_av_readdata = rdata_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q <= IRE_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= i_av.writedata[7:0] & IRE_CTRL_WMASK;
    end
  end

  // prescaler and divisor zero give fastest rate
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rate_q <= IRE_RATE_RESET;
    end else begin
      if (wr_rate_b0) begin
        rate_q.divisor <= i_av.writedata[IRE_RATE_DIV_LSB +: 8];
      end
      if (wr_rate_b1) begin
        rate_q.prescale <= i_av.writedata[IRE_RATE_PRE_LSB +: 2];
      end
      if (wr_rate_b2) begin
        rate_q.smart <= i_av.writedata[IRE_RATE_SMART_BIT];
      end
    end
  end

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx0_sync_q <= 2'b11;
      rxo_meta_q <= '1;
      rxo_sync_q <= '1;
    end else begin
      rx0_sync_q <= {rx0_sync_q[0], i_serial_rx_pin_ch0};
      rxo_meta_q <= i_other_rx_pin;
      rxo_sync_q <= rxo_meta_q;
    end
  end

  // Encoder: a zero bit sends one pulse at the start of its bit time
  wire start_pulse = ctrl_q.enable & i_core_bit_stb & ~i_core_txd;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      IRE_IDLE: begin
        if (start_pulse) begin
          state_d = IRE_PULSE;
          cnt_d   = width - 24'h000001;
        end
      end
      IRE_PULSE: begin
        if (cnt_q == '0) begin
          state_d = IRE_GAP;
        end else begin
          cnt_d = cnt_q - 24'h000001;
        end
      end
      IRE_GAP: begin
        // Take a strobe landing in the cycle after the pulse's last cycle
        state_d = start_pulse ? IRE_PULSE : IRE_IDLE;
        cnt_d   = start_pulse ? width - 24'h000001 : cnt_q;
      end
      default: begin
        state_d = IRE_IDLE;
        cnt_d   = '0;
      end
    endcase
    // Leaving infrared mode aborts any pulse in flight
    if (!ctrl_q.enable) begin
      state_d = IRE_IDLE;
      cnt_d   = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= IRE_IDLE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // optional output inversion
  // Pin register tracks next state, so the pulse lasts exactly width clocks
  wire ir_tx   = (state_d == IRE_PULSE) ^ ctrl_q.tx_inv;
  wire ir_rx   = rx0_sync_q[1] ^ ctrl_q.rx_inv;
  wire tx_sel  = ctrl_q.enable ? ir_tx : i_core_txd;
  wire rx_sel  = ctrl_q.enable ? ir_rx : rx0_sync_q[1];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_pin_q   <= 1'b1;
      rxd_q      <= 1'b1;
      other_tx_q <= '1;
    end else begin
      tx_pin_q   <= tx_sel;
      rxd_q      <= rx_sel;
      other_tx_q <= i_other_txd;
    end
  end

  assign o_serial_tx_pin_ch0 = tx_pin_q;
  assign o_core_rxd          = rxd_q;
  assign o_other_tx_pin      = other_tx_q;
  assign o_other_rxd         = rxo_sync_q;

endmodule : ire_top

`default_nettype wire

// File: tb/irda_pulse_encoder_ctrl_tb_top.sv
// Testbench for the infrared encoder control block
`default_nettype none
module irda_pulse_encoder_ctrl_tb_top
  import ire_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_rst_b = 1'b0, txd = 1'b1, stb = 1'b0;
  logic rx_pin, tx_pin, rxd, wq;
  logic [0:0] otx = 1'b1, orx = 1'b1, opin, orxd;
  logic [31:0] rd, rdat, cnt;
  ire_av_req_s av = '0;
  int errors = 0, num_checks = 0;
  ire_top DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_av(av), .o_av_readdata(rd),
    .o_av_waitrequest(wq), .i_core_txd(txd), .i_core_bit_stb(stb), .o_core_rxd(rxd),
    .o_serial_tx_pin_ch0(tx_pin), .i_serial_rx_pin_ch0(rx_pin), .i_other_txd(otx),
    .o_other_tx_pin(opin), .i_other_rx_pin(orx), .o_other_rxd(orxd));
  ire_xcvr_model xcvr (.i_clk(i_clk), .i_tx_led(tx_pin), .o_rx_diode(rx_pin));
  always #4 i_clk = ~i_clk;
  task automatic print_verdict;
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // Request held until waitrequest is sampled low at a rising edge, then released
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    av <= '{a, !w, w, d, 4'hF};
    do begin
      @(posedge i_clk);
      n++;
    end while (wq !== 1'b0 && n < 20);
    if (wq !== 1'b0) begin
      errors++;
      print_verdict();
    end else begin
      rdat = rd;
      av.read <= 1'b0;
      av.write <= 1'b0;
    end
  endtask : xfer
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    cmp(rdat, exp);
  endtask : rd_chk
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd_chk(IRE_OFS_CTRL, 32'h0);
    rd_chk(IRE_OFS_RATE, 32'h0);
    rd_chk(4'hC, 32'h0);
    xfer(1'b0, IRE_OFS_STATUS, 32'h0);
    cmp(rdat >> 8, 32'd32);
    // Settings present but infrared off: pins stay plain
    xfer(1'b1, IRE_OFS_CTRL, 32'h7F);
    rd_chk(IRE_OFS_CTRL, 32'h7C);
    txd <= 1'b0;
    repeat (6) @(posedge i_clk);
    cmp({tx_pin, rxd}, 32'h0);
    txd <= 1'b1;
    repeat (6) @(posedge i_clk);
    cmp({tx_pin, rxd}, 32'h3);
    // Bit period 160 clocks, so the widest pulse still fits
    xfer(1'b1, IRE_OFS_RATE, 32'h4);
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, IRE_OFS_CTRL, {24'h0, 1'b1, c[2:0], c[0], c[1], 2'b11});
      rd_chk(IRE_OFS_CTRL, {24'h0, 1'b1, c[2:0], c[0], c[1], 2'b00});
      stb <= 1'b1;
      txd <= 1'b0;
      otx <= ~otx;
      orx <= ~orx;
      @(posedge i_clk);
      stb <= 1'b0;
      txd <= 1'b1;
      cnt = 0;
      repeat (150) begin
        @(negedge i_clk);
        cnt += {31'h0, tx_pin === !c[0]};
      end
      cmp(cnt, c == 0 ? 32'd30 : 32'd1 << c);
    end
    // Odd toggle count, so a stuck pass-through cannot match
    @(posedge i_clk);
    otx <= ~otx;
    orx <= ~orx;
    repeat (3) @(posedge i_clk);
    cmp({opin, orxd}, {otx, orx});
    xfer(1'b1, IRE_OFS_RATE, 32'h10000);
    xfer(1'b0, IRE_OFS_STATUS, 32'h0);
    cmp(rdat >> 8, 32'd744);
    print_verdict();
  end
endmodule : irda_pulse_encoder_ctrl_tb_top
`default_nettype wire

// File: tb/ire_top_monitor.sv
// Port checker for the infrared encoder control
`default_nettype none
module ire_top_monitor
  import ire_pkg::*;
#(parameter int N_OTHER = 1) (
  // Clock and reset
  input wire logic               i_clk,
  input wire logic               i_rst_b,
  // Watched ports
  input wire ire_pkg::ire_av_req_s i_av,
  input wire logic [31:0]        o_av_readdata,
  input wire logic               o_av_waitrequest,
  input wire logic               i_core_txd,
  input wire logic               i_core_bit_stb,
  input wire logic               o_core_rxd,
  input wire logic               o_serial_tx_pin_ch0,
  input wire logic               i_serial_rx_pin_ch0,
  input wire logic [N_OTHER-1:0] i_other_txd,
  input wire logic [N_OTHER-1:0] o_other_tx_pin,
  input wire logic [N_OTHER-1:0] i_other_rx_pin,
  input wire logic [N_OTHER-1:0] o_other_rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Control mirror, updated on the taking edge like the register
  logic [7:0] ctrl_q;
  wire logic tk = o_av_waitrequest && i_av.address == IRE_OFS_CTRL;
  wire logic go = ctrl_q[7] && i_core_bit_stb && !i_core_txd;
  wire logic pv = o_serial_tx_pin_ch0 != ctrl_q[3];
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) ctrl_q <= 8'h00;
    else if (tk && i_av.write && i_av.byteenable[0])
      ctrl_q <= i_av.writedata[7:0] & IRE_CTRL_WMASK;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  one_wait_a:
    assert property ((i_av.read || i_av.write) && o_av_waitrequest |=> !o_av_waitrequest)
    else $error("wait state not single");
  ctrl_read_a:
    assert property (i_av.read && tk |=> o_av_readdata == {24'h000000, ctrl_q})
    else $error("control readback wrong");
  other_tx_a:
    assert property (o_other_tx_pin == $past(i_other_txd)) else $error("other tx disturbed");
  other_rx_a:
    assert property (o_other_rxd == $past(i_other_rx_pin, 2)) else $error("other rx disturbed");
  serial_tx_a:
    assert property (!$past(ctrl_q[7]) |-> o_serial_tx_pin_ch0 == $past(i_core_txd))
    else $error("serial tx not plain");
  rx_path_a:
    assert property (o_core_rxd == ($past(i_serial_rx_pin_ch0, 3) ^ $past(ctrl_q[7] & ctrl_q[2])))
    else $error("receive level wrong");
  pulse_two_a:
    assert property (go && ctrl_q[6:4] == 3'h1 |-> ##1 pv [*2] ##1 !pv)
    else $error("pulse width 2 wrong");
  pulse_four_a:
    assert property (go && ctrl_q[6:4] == 3'h2 |-> ##1 pv [*4] ##1 !pv)
    else $error("pulse width 4 wrong");
  pulse_eight_a:
    assert property (go && ctrl_q[6:4] == 3'h3 |-> ##1 pv [*8] ##1 !pv)
    else $error("pulse width 8 wrong");
endmodule : ire_top_monitor
bind ire_top ire_top_monitor #(.N_OTHER(N_OTHER)) u_mon (
  .i_clk               (i_clk),
  .i_rst_b             (i_rst_b),
  .i_av                (i_av),
  .o_av_readdata       (o_av_readdata),
  .o_av_waitrequest    (o_av_waitrequest),
  .i_core_txd          (i_core_txd),
  .i_core_bit_stb      (i_core_bit_stb),
  .o_core_rxd          (o_core_rxd),
  .o_serial_tx_pin_ch0 (o_serial_tx_pin_ch0),
  .i_serial_rx_pin_ch0 (i_serial_rx_pin_ch0),
  .i_other_txd         (i_other_txd),
  .o_other_tx_pin      (o_other_tx_pin),
  .i_other_rx_pin      (i_other_rx_pin),
  .o_other_rxd         (o_other_rxd)
);
`default_nettype wire

// File: tb/ire_xcvr_model.sv
// Behavioural infrared transceiver on the channel 0 pins
`default_nettype none
module ire_xcvr_model (
  // Clock
  input  wire logic i_clk,
  // Optical side
  input  wire logic i_tx_led,
  output logic      o_rx_diode
);
  timeunit 1ns;
  timeprecision 1ps;
  // Starts dark-idle high so the receive path settles like the pins
  initial o_rx_diode = 1'b1;
  // Own light is seen again one clock later
  always @(posedge i_clk) o_rx_diode <= i_tx_led;
endmodule : ire_xcvr_model
`default_nettype wire
